// [rtl/fidp_core.sv]
`timescale 1ns/100ps
`default_nettype none
module fidp_core
    import fidp_pkg::*;
#(
    parameter logic [15:0] MAKER_ID_VALUE = 16'h0A5A, // arbitrary value
    parameter logic [15:0] PART_ID_VALUE  = 16'h1234  // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_data,
    input  wire logic        prog_word_start,
    input  wire logic        prog_buf_start,
    input  wire logic        erase_start,
    input  wire logic        suspend_req,
    input  wire logic        resume_req,
    input  wire logic        id_read,
    input  wire logic [20:0] id_addr,
    input  wire logic [31:0] block_locks,
    input  wire logic [15:0] bus_config_value,
    input  wire logic        otp_write,
    input  wire logic [3:0]  otp_index,
    input  wire logic [15:0] otp_word_data,
    output logic [15:0]      id_data,
    output logic             cfg_rejected,
    output logic             cfg_code_error,
    output logic             otp_locked_error,
    output logic             controller_busy,
    output logic             op_suspended,
    output logic [1:0]       pin_mode_code,
    output logic             op_done_pin_o,
    output logic             op_done_pin_oe
);
    typedef struct packed {
        fidp_state_t                state;
        fidp_state_t                resume_to;
        logic [TIMER_WIDTH-1:0]     timer;
        logic [PULSE_CNT_WIDTH-1:0] pulse_cnt;
        logic [1:0]                 mode;
        logic                       code_error;
        logic                       rejected;
        logic                       otp_error;
        logic [15:0]                rdata;
        logic [OTP_WORD_COUNT*16-1:0] otp;
    } fidp_regs_t;

    fidp_regs_t r;
    fidp_regs_t next_r;

    logic        done_prog;
    logic        done_erase;
    logic [15:0] otp_lock;
    logic [3:0]  otp_rd_idx;

    assign otp_lock   = r.otp[15:0];
    assign otp_rd_idx = 4'(id_addr - ADDR_OTP_LOCK);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_r     = r;
        done_prog  = 1'b0;
        done_erase = 1'b0;
        next_r.rejected = 1'b0;
        if (r.timer != '0) begin
            next_r.timer = r.timer - 1'b1;
        end
        case (r.state)
            FIDP_IDLE: begin
                if (prog_word_start) begin
                    next_r.state = FIDP_PROG_WORD;
                    next_r.timer = TIMER_WIDTH'(WORD_PROG_MAX_CYCLES - 1);
                end else if (prog_buf_start) begin
                    next_r.state = FIDP_PROG_BUF;
                    next_r.timer = TIMER_WIDTH'(BUF_PROG_MAX_CYCLES - 1);
                end else if (erase_start) begin
                    next_r.state = FIDP_ERASE;
                    next_r.timer = TIMER_WIDTH'(WORD_PROG_MAX_CYCLES - 1);
                end
            end
            FIDP_PROG_WORD, FIDP_PROG_BUF, FIDP_ERASE: begin
                if (suspend_req) begin
                    next_r.resume_to = r.state;
                    if (r.state == FIDP_ERASE) begin
                        next_r.state = FIDP_SUSP_ERASE;
                        next_r.timer = TIMER_WIDTH'(ERASE_SUSP_MAX_CYCLES - 1);
                    end else begin
                        next_r.state = FIDP_SUSP_PROG;
                        next_r.timer = TIMER_WIDTH'(PROG_SUSP_MAX_CYCLES - 1);
                    end
                end else if (r.timer == '0) begin
                    next_r.state = FIDP_IDLE;
                    done_erase   = (r.state == FIDP_ERASE);
                    done_prog    = (r.state != FIDP_ERASE);
                end
            end
            FIDP_SUSP_PROG, FIDP_SUSP_ERASE: begin
                // pause a few cycles in, well under either latency limit
                if (r.timer[3:0] == 4'h0) begin
                    next_r.state = FIDP_PAUSED;
                end
            end
            FIDP_PAUSED: begin
                if (resume_req) begin
                    next_r.state = r.resume_to;
                    next_r.timer = TIMER_WIDTH'(PROG_SUSP_MAX_CYCLES - 1);
                end
            end
            default: next_r.state = FIDP_IDLE;
        endcase

        // pin mode configure
        if (cfg_write) begin
            if (r.state != FIDP_IDLE) begin
                next_r.rejected = 1'b1;
            end else if (cfg_data[7:PIN_MODE_CODE_WIDTH] != '0) begin
                next_r.code_error = 1'b1;
            end else begin
                next_r.mode = cfg_data[PIN_MODE_CODE_WIDTH-1:0];
            end
        end

        // otp lock word and otp words 1 to 8, words 1 to 8 blocked by the lock word
        if (otp_write && r.state == FIDP_IDLE) begin
            if (otp_index == 4'h0) begin
                next_r.otp[15:0] = r.otp[15:0] & otp_word_data;
            end else if (otp_index <= 4'h4 && !otp_lock[OTP_FACTORY_LOCK_BIT]) begin
                next_r.otp_error = 1'b1;
            end else if (otp_index >= 4'h5 && otp_index <= 4'h8 && !otp_lock[OTP_USER_LOCK_BIT]) begin
                next_r.otp_error = 1'b1;
            end else if (otp_index <= 4'h8) begin
                next_r.otp[otp_index*16 +: 16] = r.otp[otp_index*16 +: 16] & otp_word_data;
            end
        end

        // pulse generator
        if (r.pulse_cnt != '0) begin
            next_r.pulse_cnt = r.pulse_cnt - 1'b1;
        end
        if ((done_erase && r.mode[0]) || (done_prog && r.mode[1])) begin
            next_r.pulse_cnt = PULSE_CNT_WIDTH'(PULSE_LOW_CYCLES);
        end

        // identification read path
        next_r.rdata = 16'h0000;
        if (id_read) begin
            if (id_addr == ADDR_MAKER_ID) begin
                next_r.rdata = MAKER_ID_VALUE;
            end else if (id_addr == ADDR_PART_ID) begin
                next_r.rdata = PART_ID_VALUE;
            end else if (id_addr == ADDR_BUS_CONFIG) begin
                next_r.rdata = bus_config_value;
            end else if (id_addr >= ADDR_OTP_LOCK && id_addr <= ADDR_USER_OTP_LAST) begin
                next_r.rdata = r.otp[otp_rd_idx*16 +: 16];
            end else if (id_addr[15:0] == BLOCK_LOCK_OFFSET) begin
                next_r.rdata = block_locks[id_addr[20:BLOCK_INDEX_LSB]] ? BLOCK_LOCKED_WORD
                                                                          : BLOCK_OPEN_WORD;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r           <= '0;
            r.otp       <= '1;
            r.state     <= FIDP_IDLE;
            r.resume_to <= FIDP_IDLE;
            r.mode      <= PIN_MODE_READY_BUSY;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign controller_busy  = (r.state != FIDP_IDLE) && (r.state != FIDP_PAUSED);
    assign op_suspended     = (r.state == FIDP_PAUSED);
    assign id_data          = r.rdata;
    assign cfg_rejected     = r.rejected;
    assign cfg_code_error   = r.code_error;
    assign otp_locked_error = r.otp_error;
    assign pin_mode_code    = r.mode;
    assign op_done_pin_o    = 1'b0;
    // ready/busy drives low while busy; pulse modes drive only during a pulse
    assign op_done_pin_oe   = (r.mode == PIN_MODE_READY_BUSY) ? controller_busy
                                                              : (r.pulse_cnt != '0);
endmodule : fidp_core
`default_nettype wire

// [rtl/fidp_pkg.sv]
package fidp_pkg;
    // ----------------------------------------
    // pin mode codes
    // ----------------------------------------
    localparam logic [1:0] PIN_MODE_READY_BUSY  = 2'h0;
    localparam logic [1:0] PIN_MODE_PULSE_ERASE = 2'h1;
    localparam logic [1:0] PIN_MODE_PULSE_PROG  = 2'h2;
    localparam logic [1:0] PIN_MODE_PULSE_BOTH  = 2'h3;
    localparam int         PIN_MODE_CODE_WIDTH  = 2;
    // ----------------------------------------
    // identification space word addresses
    // ----------------------------------------
    localparam logic [20:0] ADDR_MAKER_ID        = 21'h000000;
    localparam logic [20:0] ADDR_PART_ID         = 21'h000001;
    localparam logic [15:0] BLOCK_LOCK_OFFSET    = 16'h0002;
    localparam logic [20:0] ADDR_BUS_CONFIG      = 21'h000005;
    localparam logic [20:0] ADDR_OTP_LOCK        = 21'h000080;
    localparam logic [20:0] ADDR_UNIQUE_ID_FIRST = 21'h000081;
    localparam logic [20:0] ADDR_UNIQUE_ID_LAST  = 21'h000084;
    localparam logic [20:0] ADDR_USER_OTP_FIRST  = 21'h000085;
    localparam logic [20:0] ADDR_USER_OTP_LAST   = 21'h000088;
    localparam int          BLOCK_INDEX_LSB      = 16;
    localparam int          OTP_WORD_COUNT       = 9;
    localparam int          OTP_USER_LOCK_BIT    = 1;
    localparam int          OTP_FACTORY_LOCK_BIT = 0;
    localparam logic [15:0] BLOCK_LOCKED_WORD    = 16'h0001;
    localparam logic [15:0] BLOCK_OPEN_WORD      = 16'h0000;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS         = 25000;
    localparam int PULSE_LOW_NS          = 250;
    localparam int PULSE_LOW_CYCLES      = (PULSE_LOW_NS * 1000) / CLK_PERIOD_PS;
    localparam int WORD_PROG_MAX_US      = 48;
    localparam int BUF_PROG_MAX_US       = 576;
    localparam int PROG_SUSPEND_MAX_US   = 20;
    localparam int ERASE_SUSPEND_MAX_US  = 25;
    localparam int WORD_PROG_MAX_CYCLES  = (WORD_PROG_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int BUF_PROG_MAX_CYCLES   = (BUF_PROG_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int PROG_SUSP_MAX_CYCLES  = (PROG_SUSPEND_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int ERASE_SUSP_MAX_CYCLES = (ERASE_SUSPEND_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int TIMER_WIDTH           = 16;
    localparam int PULSE_CNT_WIDTH       = 4;
    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [2:0] {
        FIDP_IDLE       = 3'b000,
        FIDP_PROG_WORD  = 3'b001,
        FIDP_PROG_BUF   = 3'b010,
        FIDP_ERASE      = 3'b011,
        FIDP_SUSP_PROG  = 3'b100,
        FIDP_SUSP_ERASE = 3'b101,
        FIDP_PAUSED     = 3'b110
    } fidp_state_t;
endpackage : fidp_pkg

// [verif/fidp_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module fidp_chk
    import fidp_pkg::*;
#(
    parameter logic [15:0] MAKER_ID_VALUE = 16'h0A5A, // arbitrary value
    parameter logic [15:0] PART_ID_VALUE  = 16'h1234  // arbitrary value
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_data,
    input wire logic        prog_word_start,
    input wire logic        prog_buf_start,
    input wire logic        erase_start,
    input wire logic        suspend_req,
    input wire logic        id_read,
    input wire logic [20:0] id_addr,
    input wire logic [31:0] block_locks,
    input wire logic [15:0] bus_config_value,
    input wire logic [15:0] id_data,
    input wire logic        cfg_rejected,
    input wire logic        cfg_code_error,
    input wire logic        controller_busy,
    input wire logic        op_suspended,
    input wire logic [1:0]  pin_mode_code,
    input wire logic        op_done_pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic        was_erase;
    logic        was_word;
    logic [4:0]  oe_run;
    logic [11:0] word_run;
    // the ports do not say which kind of operation ended, so remember the last start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            was_erase <= 1'b0;
            was_word  <= 1'b0;
        end else if (!controller_busy && !op_suspended && (erase_start || prog_word_start || prog_buf_start)) begin
            was_erase <= erase_start;
            was_word  <= prog_word_start;
        end
    end
    // long spans are counted here rather than unrolled in a sequence
    always_ff @(posedge ref_clk) begin
        if (rst || !op_done_pin_oe) begin
            oe_run <= 5'h00;
        end else if (oe_run != 5'h1F) begin
            oe_run <= oe_run + 5'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst || !(controller_busy && was_word)) begin
            word_run <= 12'h000;
        end else begin
            word_run <= word_run + 12'h001;
        end
    end
    AST_RB_BUSY: assert property (pin_mode_code == 2'h0 && controller_busy && !op_suspended |-> op_done_pin_oe)
        else $error("pin released during busy");
    AST_RB_READY: assert property (pin_mode_code == 2'h0 && !controller_busy && !op_suspended |-> !op_done_pin_oe)
        else $error("pin driven while ready");
    AST_PULSE_WANTED: assert property ($fell(controller_busy) && !op_suspended &&
        (pin_mode_code == 2'h3 || pin_mode_code == (was_erase ? 2'h1 : 2'h2)) |-> ##[0:2] op_done_pin_oe)
        else $error("missing completion pulse");
    AST_PULSE_UNWANTED: assert property ($fell(controller_busy) && pin_mode_code == (was_erase ? 2'h2 : 2'h1)
        |-> !op_done_pin_oe [*3]) else $error("pulse for wrong operation");
    AST_PULSE_WIDTH: assert property ($fell(op_done_pin_oe) && pin_mode_code != 2'h0
        |-> oe_run == 5'h0A) else $error("pulse width wrong");
    AST_PULSE_NO_BUSY: assert property (pin_mode_code != 2'h0 && controller_busy |-> !op_done_pin_oe)
        else $error("busy shown in pulse mode");
    AST_ID_MAKER: assert property (id_read && id_addr == ADDR_MAKER_ID |=> id_data == MAKER_ID_VALUE)
        else $error("maker word wrong");
    AST_ID_PART: assert property (id_read && id_addr == ADDR_PART_ID |=> id_data == PART_ID_VALUE)
        else $error("part word wrong");
    AST_ID_BUSCFG: assert property (id_read && id_addr == ADDR_BUS_CONFIG
        |=> id_data == $past(bus_config_value)) else $error("bus config readback wrong");
    AST_LOCK_SET: assert property (id_read && id_addr[15:0] == BLOCK_LOCK_OFFSET && block_locks[id_addr[20:16]]
        |=> id_data == BLOCK_LOCKED_WORD) else $error("locked block reads open");
    AST_CFG_REFUSE: assert property (cfg_write && (controller_busy || op_suspended)
        |=> cfg_rejected && $stable(pin_mode_code)) else $error("configure taken while busy");
    AST_CFG_BADCODE: assert property (cfg_write && !controller_busy && !op_suspended && cfg_data[7:2] != 6'h00
        |=> cfg_code_error && $stable(pin_mode_code)) else $error("bad code not flagged");
    AST_CFG_TAKE: assert property (cfg_write && !controller_busy && !op_suspended && cfg_data[7:2] == 6'h00
        |=> {6'h00, pin_mode_code} == $past(cfg_data)) else $error("mode code not taken");
    AST_WORD_TIME: assert property (controller_busy && was_word
        |-> word_run < 12'h780) else $error("word program too long");
    AST_PSUSP: assert property (suspend_req && controller_busy && !op_suspended && !was_erase
        |-> ##[1:800] op_suspended) else $error("program suspend too slow");
    AST_ESUSP: assert property (suspend_req && controller_busy && !op_suspended && was_erase
        |-> ##[1:1000] op_suspended) else $error("erase suspend too slow");
endmodule : fidp_chk
bind fidp_core fidp_chk #(.MAKER_ID_VALUE(MAKER_ID_VALUE), .PART_ID_VALUE(PART_ID_VALUE)) fidp_chk_inst (.*);
`default_nettype wire

// [verif/fidp_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fidp_host (
    input  wire logic op_done_pin_oe,
    output wire logic op_done_pin
);
    // open drain pin with a board pull-up: released means high, never a held level
    assign op_done_pin = op_done_pin_oe ? 1'b0 : 1'b1;
endmodule : fidp_host
`default_nettype wire

// [verif/flash_id_space_and_done_pin_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module flash_id_space_and_done_pin_bench;
    import fidp_pkg::*;
    typedef struct {logic [20:0] a; logic [15:0] d;} fidp_row_t;
    logic        ref_clk = 1'b0, rst = 1'b1, pin_q = 1'b1;
    logic        cfg_write, prog_word_start, prog_buf_start, erase_start, suspend_req, resume_req, id_read, otp_write;
    logic [7:0]  cfg_data;
    logic [20:0] id_addr;
    logic [31:0] block_locks = 32'h0000_0004;
    logic [15:0] bus_config_value = 16'hC3A5;
    logic [3:0]  otp_index;
    logic [15:0] otp_word_data, id_data;
    logic        cfg_rejected, cfg_code_error, otp_locked_error, controller_busy, op_suspended;
    logic        op_done_pin_o, op_done_pin_oe, op_done_pin;
    logic [1:0]  pin_mode_code;
    int          n_fail = 0, samples_checked = 0, n_pulses = 0;
    fidp_row_t   rows [8] = '{'{21'h000000, 16'h0A5A}, '{21'h000001, 16'h1234}, '{21'h000005, 16'hC3A5},
        '{21'h020002, 16'h0001}, '{21'h030002, 16'h0000}, '{21'h000080, 16'hFFFF},
        '{21'h000084, 16'hFFFF}, '{21'h000088, 16'hFFFF}};
    // identity values are arbitrary
    fidp_core #(.MAKER_ID_VALUE(16'h0A5A), .PART_ID_VALUE(16'h1234)) fidp_core_inst (.*);
    fidp_host fidp_host_inst (.op_done_pin_oe(op_done_pin_oe), .op_done_pin(op_done_pin));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (pin_q && !op_done_pin) n_pulses++;
        pin_q <= op_done_pin;
    end
    task automatic tick(); @(posedge ref_clk); #2; endtask : tick
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // strobes are held for one edge and then left low for one more, so re-entry is safe
    task automatic pulse(ref logic s); s = 1'b1; tick(); s = 1'b0; tick(); endtask : pulse
    task automatic wait_on(input bit susp, input int lim);
        for (int i = 0; i < lim && (susp ? !op_suspended : controller_busy); i++) tick();
        if (susp ? !op_suspended : controller_busy) begin
            n_fail++;
            complete_run();
        end
    endtask : wait_on
    task automatic run_op(ref logic s, input int lim); pulse(s); wait_on(0, lim); repeat (14) tick(); endtask : run_op
    task automatic susp_op(ref logic s, input int lim);
        pulse(s);
        repeat (100) tick();
        pulse(suspend_req);
        wait_on(1, lim);
        check("suspended", op_suspended, 1'b1);
        pulse(resume_req);
        wait_on(0, 1930);
    endtask : susp_op
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {cfg_write, prog_word_start, prog_buf_start, erase_start, suspend_req, resume_req, id_read, otp_write} = '0;
        {cfg_data, id_addr, otp_index, otp_word_data} = '0;
        repeat (5) @(posedge ref_clk);
        #2 rst = 1'b0;
        check("mode", pin_mode_code, 2'h0);
        check("pin_oe", op_done_pin_oe, 1'b0);
        foreach (rows[i]) begin
            id_addr = rows[i].a;
            id_read = 1'b1;
            tick();
            id_read = 1'b0;
            check("id_word", id_data, rows[i].d);
            tick();
        end
        otp_word_data = 16'hFFFD;
        pulse(otp_write);
        otp_index = 4'h6;
        otp_word_data = 16'h0000;
        pulse(otp_write);
        check("otp_lock", otp_locked_error, 1'b1);
        pulse(prog_word_start);
        check("pin_low", op_done_pin, 1'b0);
        cfg_data = 8'h01; // host keeps reserved bits zero
        pulse(cfg_write);
        wait_on(0, 1930);
        check("mode_kept", pin_mode_code, 2'h0);
        susp_op(prog_word_start, 800);
        susp_op(erase_start, 1000);
        cfg_data = 8'h44;
        pulse(cfg_write);
        check("code_err", cfg_code_error, 1'b1);
        check("mode_kept", pin_mode_code, 2'h0);
        run_op(prog_buf_start, 23041);
        for (int m = 1; m < 4; m++) begin
            cfg_data = 8'(m);
            pulse(cfg_write);
            check("mode", pin_mode_code, 16'(m));
            n_pulses = 0;
            run_op(erase_start, 1930);
            run_op(prog_word_start, 1930);
            check("pulses", 16'(n_pulses), (m == 3) ? 16'h2 : 16'h1);
        end
        complete_run();
    end
endmodule : flash_id_space_and_done_pin_bench
`default_nettype wire
